/* File: wbe_master.sv */
// initiating end: turns user beats into bus cycles
`default_nettype none
module wbe_master import wbe_pkg::*; (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic ifaceReset,
    input wire logic cmdValid,
    output logic cmdReady,
    input wire logic cmdWe,
    input wire logic [ADR_HI:ADR_LO] cmdAdr,
    input wire logic [SEL_W-1:0] cmdSel,
    input wire logic [DAT_W-1:0] cmdWdat,
    input wire logic [TGA_W-1:0] cmdTga,
    input wire logic [TGC_W-1:0] cmdTgc,
    input wire logic cmdLock,
    input wire logic cmdLast,
    output logic rspValid,
    output logic [1:0] rspStatus,
    output logic [DAT_W-1:0] rspRdat,
    wbe_bus_if.mst bus
);
    typedef struct packed {
        wbe_mst_state_type state;
        logic busRst;
        logic cyc;
        logic stb;
        logic we;
        logic lock;
        logic [ADR_HI:ADR_LO] adr;
        logic [SEL_W-1:0] sel;
        logic [DAT_W-1:0] wdat;
        logic [TGA_W-1:0] tga;
        logic [TGC_W-1:0] tgc;
        logic last;
        logic rspValid;
        logic [1:0] rspStatus;
        logic [DAT_W-1:0] rdat;
    } wbe_mst_reg_type;

    localparam wbe_mst_reg_type MST_RESET = '{
        state: MS_IDLE, busRst: 1'b1, default: '0};

    wbe_mst_reg_type st_q;
    wbe_mst_reg_type st_d;
    logic take;
    logic abnormal;

    // beats are taken only between strobes, never mid-handshake
    assign cmdReady = !st_q.busRst && (st_q.state != MS_STRB);
    assign take = cmdValid && cmdReady;
    assign abnormal = bus.err || bus.rty;

    // next-state logic
    always_comb begin
        st_d = st_q;
        st_d.rspValid = 1'b0;
        st_d.busRst = ifaceReset;
        if (st_q.busRst) begin
            st_d = MST_RESET; // RULE_18
            st_d.busRst = ifaceReset;
        end else begin
            unique case (st_q.state)
                MS_IDLE, MS_GAP: begin
                    if (take) begin
                        st_d.cyc = 1'b1; // RULE_11
                        st_d.stb = 1'b1; // RULE_05
                        st_d.we = cmdWe; // RULE_09
                        st_d.adr = cmdAdr; // RULE_10
                        st_d.sel = cmdSel; // RULE_04
                        st_d.wdat = cmdWdat;
                        st_d.tga = cmdTga; // RULE_07
                        st_d.lock = cmdLock; // RULE_02
                        st_d.last = cmdLast;
                        st_d.state = MS_STRB;
                        if (st_q.state == MS_IDLE) begin
                            st_d.tgc = cmdTgc; // RULE_08
                        end
                    end
                end
                MS_STRB: begin
                    // any one terminator ends this strobe
                    if (bus.ack || abnormal) begin
                        st_d.stb = 1'b0; // RULE_19
                        st_d.rspValid = 1'b1;
                        st_d.rdat = bus.datS2M;
                        st_d.rspStatus = bus.err ? ST_ERR :
                            (bus.rty ? ST_RTY : ST_OK); // RULE_14
                        if (!abnormal && !st_q.last) begin
                            st_d.state = MS_GAP; // RULE_11
                        end else begin
                            // error or retry ends the whole cycle
                            st_d.cyc = 1'b0; // RULE_01 RULE_03
                            st_d.lock = 1'b0;
                            st_d.state = st_q.last ? MS_IDLE : MS_DRAIN;
                        end
                    end
                end
                MS_DRAIN: begin
                    // rest of an aborted block is dropped; user retries
                    if (take && cmdLast) begin
                        st_d.state = MS_IDLE;
                    end
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= MST_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // every bus output straight from a flop
    assign bus.rst = st_q.busRst; // RULE_16 RULE_17
    assign bus.cyc = st_q.cyc;
    assign bus.stb = st_q.stb;
    assign bus.we = st_q.we;
    assign bus.lock = st_q.lock;
    assign bus.adr = st_q.adr;
    assign bus.sel = st_q.sel;
    assign bus.datM2S = st_q.wdat;
    assign bus.tga = st_q.tga;
    assign bus.tgc = st_q.tgc;
    assign rspValid = st_q.rspValid;
    assign rspStatus = st_q.rspStatus;
    assign rspRdat = st_q.rdat;
endmodule // wbe_master
`default_nettype wire

/* File: wbe_pkg.sv */
// shared constants and types for the bus endpoint pair
`default_nettype none
package wbe_pkg;
    // port shape: 64-bit data, byte granular lanes
    localparam int DAT_W = 64;
    localparam int LANE_W = 8;
    localparam int SEL_W = DAT_W / LANE_W;
    localparam int ADR_HI = 31;
    localparam int ADR_LO = 3;
    // address tag: bit 0 marks a privileged access
    localparam int TGA_W = 2;
    localparam int TGA_PRIV = 0;
    // cycle tag encodings
    localparam int TGC_W = 2;
    localparam logic [1:0] TGC_SINGLE = 2'h0;
    localparam logic [1:0] TGC_BLOCK = 2'h1;
    localparam logic [1:0] TGC_RMW = 2'h2;
    // answer status toward the master's user
    localparam logic [1:0] ST_OK = 2'h0;
    localparam logic [1:0] ST_ERR = 2'h1;
    localparam logic [1:0] ST_RTY = 2'h2;
    // slave storage and decode
    localparam int IDX_W = 4;
    localparam int MEM_WORDS = 16;
    localparam logic [3:0] PROT_FIRST = 4'hc;
    localparam logic [24:0] SLV_BASE = 25'h0000000;
    typedef logic [ADR_HI:ADR_LO] wbe_adr_type;
    typedef enum logic [1:0] {
        MS_IDLE = 2'b00,
        MS_STRB = 2'b01,
        MS_GAP = 2'b11,
        MS_DRAIN = 2'b10
    } wbe_mst_state_type;
endpackage
`default_nettype wire

/* File: wbe_bus_if.sv */
// bus wires joining the initiating and responding ends
`default_nettype none
interface wbe_bus_if import wbe_pkg::*; ();
    logic rst;
    logic cyc;
    logic stb;
    logic we;
    logic lock;
    wbe_adr_type adr;
    logic [SEL_W-1:0] sel;
    logic [DAT_W-1:0] datM2S;
    logic [DAT_W-1:0] datS2M;
    logic [TGA_W-1:0] tga;
    logic [TGC_W-1:0] tgc;
    logic ack;
    logic err;
    logic rty;
    modport mst (
        output rst, cyc, stb, we, lock, adr, sel, datM2S, tga, tgc,
        input datS2M, ack, err, rty
    );
    modport slv (
        input rst, cyc, stb, we, lock, adr, sel, datM2S, tga, tgc,
        output datS2M, ack, err, rty
    );
endinterface
`default_nettype wire

/* File: wbe_lane_merge.sv */
// per-lane write merge and read masking
`default_nettype none
module wbe_lane_merge import wbe_pkg::*; (
    input wire logic [DAT_W-1:0] oldWord,
    input wire logic [DAT_W-1:0] newWord,
    input wire logic [SEL_W-1:0] laneSel,
    output logic [DAT_W-1:0] mergedWord,
    output logic [DAT_W-1:0] maskedWord
);
    // unselected lanes keep old data on write, read as zero
    genvar g;
    generate
        for (g = 0; g < SEL_W; g++) begin : gLane
            assign mergedWord[g*LANE_W +: LANE_W] = laneSel[g] ?
                newWord[g*LANE_W +: LANE_W] : oldWord[g*LANE_W +: LANE_W];
            assign maskedWord[g*LANE_W +: LANE_W] = laneSel[g] ?
                oldWord[g*LANE_W +: LANE_W] : {LANE_W{1'b0}};
        end
    endgenerate
endmodule // wbe_lane_merge
`default_nettype wire

/* File: wbe_slave.sv */
// responding end: small lane-addressed store behind the bus
`default_nettype none
// How it works
// (RULE_01) error ends the cycle abnormally
// (RULE_02) locked cycle keeps one owner until release
// (RULE_03) not ready answers with retry
// (RULE_04) one select bit per byte lane
// (RULE_05) strobe qualifies select, tags and data
// (RULE_06) exactly one terminator per strobe
// (RULE_07) address tag valid only with strobe
// (RULE_08) cycle tag valid only with cycle
// (RULE_09) write enable low reads, high writes
// (RULE_10) address spans core width down to port
// (RULE_11) cycle held across all transfers
// (RULE_12) locked slave serves one master only
// (RULE_13) respond only while strobe, except reset
// (RULE_14) acknowledge means normal termination
// (RULE_15) selects choose valid write and read lanes
// (RULE_16) outputs registered on rising edge
// (RULE_17) all bus signals active high
// (RULE_18) bus reset restarts interface state
// (RULE_19) at most one terminator per cycle
module wbe_slave import wbe_pkg::*; (
    input wire logic sys_clk,
    input wire logic rst_b,
    wbe_bus_if.slv bus,
    input wire logic slvBusy,
    input wire logic userReq,
    input wire logic userWe,
    input wire logic [IDX_W-1:0] userAdr,
    input wire logic [DAT_W-1:0] userWdat,
    output logic userGnt,
    output logic [DAT_W-1:0] userRdat,
    output logic slvLocked,
    output logic [TGC_W-1:0] slvCycKind
);
    // everything the slave remembers, registered as one word
    typedef struct packed {
        logic ack;
        logic err;
        logic rty;
        logic [DAT_W-1:0] rdat;
        logic lockHeld;
        logic [TGC_W-1:0] cycKind;
        logic [DAT_W-1:0] userRdat;
        logic [MEM_WORDS-1:0][DAT_W-1:0] mem;
    } wbe_slv_reg_type;

    // power-on value clears the store as well;
    // the bus reset alone keeps it
    localparam wbe_slv_reg_type SLV_RESET = '{default: '0};

    // present state and the value it takes at the next edge
    wbe_slv_reg_type st_q;
    wbe_slv_reg_type st_d;

    // decode of the current bus request
    logic sel;
    logic termPending;
    logic hit;
    logic [IDX_W-1:0] idx;
    logic inRange;
    logic protBlocked;
    logic [DAT_W-1:0] mergedWord;
    logic [DAT_W-1:0] maskedWord;
    // answer and store decode, one strobe at a time
    logic giveErr;
    logic giveRty;
    logic giveAck;
    logic busWrite;
    logic busRead;
    // local port and lock decode
    logic userWrite;
    logic userRead;
    logic lockNext;

    // slave is selected by strobe inside a cycle only
    assign sel = bus.cyc && bus.stb; // RULE_13

    // a terminator still showing means the strobe is answered
    assign termPending = st_q.ack || st_q.err || st_q.rty;

    // one answer per strobe: wait until our answer is gone
    assign hit = sel && !termPending && !bus.rst; // RULE_06

    // word index from the low address bits above the lanes;
    // only sixteen words, so the rest of the address is decode
    assign idx = bus.adr[ADR_LO+IDX_W-1:ADR_LO]; // RULE_10

    // upper address bits must match this slave's base
    assign inRange = (bus.adr[ADR_HI:ADR_LO+IDX_W] == SLV_BASE);

    // top words need the privileged address tag to write
    assign protBlocked = bus.we && (idx >= PROT_FIRST) &&
        !bus.tga[TGA_PRIV]; // RULE_07

    // lane work kept outside so the store logic stays readable;
    // both results come from the word the address points at now
    wbe_lane_merge wbe_lane_merge_i (
        .oldWord(st_q.mem[idx]),
        .newWord(bus.datM2S),
        .laneSel(bus.sel),
        .mergedWord(mergedWord),
        .maskedWord(maskedWord)
    );

    // local port yields to the bus and to any locked cycle;
    // this is what keeps a locked sequence atomic
    assign userGnt = userReq && !st_q.lockHeld && !sel &&
        !bus.rst; // RULE_12

    // refusals outrank the busy retry, which keeps the answer one-hot;
    // a refused strobe never touches the store
    assign giveErr = hit && (!inRange || protBlocked); // RULE_01 RULE_19

    // busy is only a level from the local side, so the master must
    // come back later; when and how is left to the master's user
    assign giveRty = hit && !giveErr && slvBusy; // RULE_03

    // whatever is neither refused nor busy ends normally
    assign giveAck = hit && !giveErr && !slvBusy; // RULE_14

    // store traffic from the bus, split by direction
    assign busWrite = giveAck && bus.we; // RULE_09 RULE_15
    assign busRead = giveAck && !bus.we; // RULE_15

    // local traffic; the grant already keeps it off bus strobes
    assign userWrite = userGnt && userWe;
    assign userRead = userGnt && !userWe;

    // lock taken with a strobe and held until lock or cycle drops;
    // a lock level without any strobe is not taken, since the slave
    // only listens while selected
    assign lockNext = bus.cyc && bus.lock &&
        (st_q.lockHeld || bus.stb); // RULE_12 RULE_13

    // next-state logic;
    // one pass decides answers, store writes and lock tracking
    always_comb begin
        st_d = st_q;
        // terminators last one cycle, then drop
        st_d.ack = 1'b0;
        st_d.err = 1'b0;
        st_d.rty = 1'b0;
        if (bus.rst) begin
            // interface restarts, stored words survive
            st_d = SLV_RESET; // RULE_18
            st_d.mem = st_q.mem;
        end else begin
            st_d.lockHeld = lockNext; // RULE_12
            if (hit) begin
                // cycle tag only looked at inside a cycle
                st_d.cycKind = bus.tgc; // RULE_08
            end

            // at most one of the three is set for a strobe
            st_d.err = giveErr; // RULE_01 RULE_19
            st_d.rty = giveRty; // RULE_03
            st_d.ack = giveAck; // RULE_14

            if (busWrite) begin
                // only selected lanes are written
                st_d.mem[idx] = mergedWord; // RULE_09 RULE_15
            end
            if (busRead) begin
                // unselected read lanes come back zero
                st_d.rdat = maskedWord; // RULE_15
            end

            // local port access, never in the same cycle as a hit
            if (userWrite) begin
                st_d.mem[userAdr] = userWdat;
            end
            if (userRead) begin
                // read port sees the store as it stood before this edge
                st_d.userRdat = st_q.mem[userAdr];
            end
        end
    end

    // state register; async reset clears everything,
    // so a read after power-up returns zero
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= SLV_RESET;
        end else begin
            st_q <= st_d; // RULE_16
        end
    end

    // bus answers come straight from flops, active high;
    // an answer made from gates would save a cycle but would break
    // the registered-output rule, so every access costs a wait state
    assign bus.ack = st_q.ack; // RULE_17
    assign bus.err = st_q.err;
    assign bus.rty = st_q.rty;
    assign bus.datS2M = st_q.rdat;

    // local side status;
    // the bus master never sees these, they serve the local user
    assign userRdat = st_q.userRdat;
    assign slvLocked = st_q.lockHeld;
    assign slvCycKind = st_q.cycKind;
endmodule // wbe_slave
`default_nettype wire

/* File: wbe_bus_props.sv */
// concurrent checks on the wires between the two bus ends
`default_nettype none
module wbe_bus_props import wbe_pkg::*; (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic rst,
    input wire logic cyc,
    input wire logic stb,
    input wire logic we,
    input wire wbe_adr_type adr,
    input wire logic ack,
    input wire logic err,
    input wire logic rty
);
    timeunit 1ns;
    timeprecision 1ps;
    // bus reset has its own check below, so it also mutes the rest
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b || rst);
    // a strobe still waiting for its answer
    sequence s_wait;
        cyc && stb && !(ack || err || rty);
    endsequence
    sequence s_term;
        ack || err || rty;
    endsequence
    property p_oneTerm;
        $onehot0({ack, err, rty});
    endproperty
    a_oneTerm: assert property (p_oneTerm)
        else $error("more than one terminator");
    property p_termCause;
        s_term |-> $past(cyc && stb);
    endproperty
    a_termCause: assert property (p_termCause)
        else $error("terminator without strobe");
    property p_answer;
        $rose(stb) |=> s_term;
    endproperty
    a_answer: assert property (p_answer)
        else $error("strobe not answered next cycle");
    property p_stbHold;
        s_wait |=> stb;
    endproperty
    a_stbHold: assert property (p_stbHold)
        else $error("strobe dropped before answer");
    property p_stbDrop;
        stb && (ack || err || rty) |=> !stb;
    endproperty
    a_stbDrop: assert property (p_stbDrop)
        else $error("strobe kept after answer");
    property p_cycOverStb;
        stb |-> cyc;
    endproperty
    a_cycOverStb: assert property (p_cycOverStb)
        else $error("strobe outside cycle");
    property p_abortEnd;
        err || rty |=> !cyc;
    endproperty
    a_abortEnd: assert property (p_abortEnd)
        else $error("cycle kept after abnormal end");
    property p_weSteady;
        s_wait |=> $stable(we);
    endproperty
    a_weSteady: assert property (p_weSteady)
        else $error("write enable moved in a transfer");
    property p_decodeErr;
        cyc && stb && !(ack || err || rty) && adr[31:7] != 25'h0 |=> err;
    endproperty
    a_decodeErr: assert property (p_decodeErr)
        else $error("outside address not refused");
    property p_busRst;
        disable iff (!rst_b) rst |=> !cyc && !stb && !(ack || err || rty);
    endproperty
    a_busRst: assert property (p_busRst)
        else $error("bus reset did not idle the bus");
endmodule // wbe_bus_props
`default_nettype wire

/* File: bus_endpoint_signal_semantics_test.sv */
// self-checking bench: master and slave joined back to back
`default_nettype none
module bus_endpoint_signal_semantics_test import wbe_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic ifaceReset, cmdValid, cmdWe, cmdLock, cmdLast, cmdReady;
    logic slvBusy, userReq, userWe, userGnt, slvLocked, rspValid;
    logic [1:0] rspStatus;
    logic [TGC_W-1:0] cmdTgc, slvCycKind;
    logic [TGA_W-1:0] cmdTga;
    logic [SEL_W-1:0] cmdSel;
    logic [IDX_W-1:0] userAdr;
    wbe_adr_type cmdAdr;
    logic [DAT_W-1:0] cmdWdat, rspRdat, userWdat, userRdat;
    logic [DAT_W-1:0] mem [MEM_WORDS];
    int errCount = 0;
    int cmpCount = 0;
    wbe_bus_if bus_i ();
    wbe_master wbe_master_i (.sys_clk(sys_clk), .rst_b(rst_b),
        .ifaceReset(ifaceReset), .cmdValid(cmdValid), .cmdReady(cmdReady),
        .cmdWe(cmdWe), .cmdAdr(cmdAdr), .cmdSel(cmdSel), .cmdWdat(cmdWdat),
        .cmdTga(cmdTga), .cmdTgc(cmdTgc), .cmdLock(cmdLock),
        .cmdLast(cmdLast), .rspValid(rspValid), .rspStatus(rspStatus),
        .rspRdat(rspRdat), .bus(bus_i));
    wbe_slave wbe_slave_i (.sys_clk(sys_clk), .rst_b(rst_b), .bus(bus_i),
        .slvBusy(slvBusy), .userReq(userReq), .userWe(userWe),
        .userAdr(userAdr), .userWdat(userWdat), .userGnt(userGnt),
        .userRdat(userRdat), .slvLocked(slvLocked), .slvCycKind(slvCycKind));
    wbe_bus_props wbe_bus_props_i (.sys_clk(sys_clk), .rst_b(rst_b),
        .rst(bus_i.rst), .cyc(bus_i.cyc), .stb(bus_i.stb), .we(bus_i.we),
        .adr(bus_i.adr), .ack(bus_i.ack), .err(bus_i.err), .rty(bus_i.rty));
    always #20 sys_clk = ~sys_clk;
    // terminator the slave should give one beat
    function automatic logic [1:0] expSt(input logic w, input wbe_adr_type a,
            input logic [TGA_W-1:0] t, input logic busy);
        if (a[31:7] != 25'h0) return ST_ERR;
        if (w && a[6:3] >= PROT_FIRST && !t[TGA_PRIV]) return ST_ERR;
        if (busy) return ST_RTY;
        return ST_OK;
    endfunction
    // byte lanes picked by a select mask
    function automatic logic [DAT_W-1:0] lanes(input logic [SEL_W-1:0] s);
        for (int i = 0; i < SEL_W; i++)
            lanes[LANE_W*i +: LANE_W] = {LANE_W{s[i]}};
    endfunction
    task automatic chk(input logic [DAT_W-1:0] seen,
            input logic [DAT_W-1:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            errCount++;
            $display("MISMATCH %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic completeRun;
        if (errCount == 0 && cmpCount > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // one beat; drained beats after an abort get no answer
    task automatic op(input logic w, input wbe_adr_type a,
            input logic [SEL_W-1:0] s, input logic [DAT_W-1:0] d,
            input logic [TGA_W-1:0] t, input logic [TGC_W-1:0] c,
            input logic lst, input logic rsp);
        int n;
        logic [1:0] st;
        n = 0;
        st = expSt(w, a, t, slvBusy);
        {cmdWe, cmdAdr, cmdSel, cmdWdat} = {w, a, s, d};
        {cmdTga, cmdTgc, cmdLast, cmdValid} = {t, c, lst, 1'b1};
        while (cmdReady !== 1'b1 && n < 100) begin
            @(posedge sys_clk);
            #1 n++;
        end
        @(posedge sys_clk);
        #1 cmdValid = 1'b0;
        while (rsp && rspValid !== 1'b1 && n < 100) begin
            @(posedge sys_clk);
            #1 n++;
        end
        if (!rsp) begin
            // let an edge pass so the next beat's valid is not reused
            @(posedge sys_clk);
            #1;
            return;
        end
        chk(rspValid, 1'b1);
        chk(rspStatus, st);
        if (st == ST_OK && !w) chk(rspRdat, mem[a[6:3]] & lanes(s));
        if (st == ST_OK && w)
            mem[a[6:3]] = (mem[a[6:3]] & ~lanes(s)) | (d & lanes(s));
    endtask
    // watchdog: the tests need well under a thousand cycles
    initial begin
        #(40 * 5000);
        errCount++;
        completeRun();
    end
    initial begin
        {ifaceReset, cmdValid, cmdLock, slvBusy, userReq, userWe} = '0;
        {cmdWe, cmdAdr, cmdSel, cmdWdat, cmdTga, cmdTgc, cmdLast} = '0;
        {userAdr, userWdat} = '0;
        for (int i = 0; i < MEM_WORDS; i++)
            mem[i] = '0;
        void'($urandom(26));
        repeat (12) @(posedge sys_clk);
        #1 rst_b = 1'b1;
        @(posedge sys_clk);
        #1;
        // random singles, a few outside the map or busy
        repeat (60) begin
            slvBusy = ($urandom % 5) == 0;
            cmdLock = 1'($urandom);
            op(1'($urandom), {($urandom % 6 == 0) ? 25'($urandom) : 25'h0,
                4'($urandom)}, 8'($urandom), {$urandom, $urandom},
                2'($urandom), TGC_SINGLE, 1'b1, 1'b1);
        end
        // block whose second beat is refused; the third is drained
        {slvBusy, cmdLock} = 2'b00;
        op(1'b1, 29'h1, 8'hff, 64'h0123456789abcdef, 2'h0, TGC_BLOCK,
            1'b0, 1'b1);
        op(1'b1, 29'hd, 8'h0f, '1, 2'h0, TGC_BLOCK, 1'b0, 1'b1);
        op(1'b0, 29'h1, 8'hff, '0, 2'h0, TGC_BLOCK, 1'b1, 1'b0);
        op(1'b0, 29'h1, 8'h3c, '0, 2'h0, TGC_SINGLE, 1'b1, 1'b1);
        // locked read-modify-write shuts out the local port
        cmdLock = 1'b1;
        op(1'b0, 29'h2, 8'hff, '0, 2'h0, TGC_RMW, 1'b0, 1'b1);
        chk(slvLocked, 1'b1);
        chk(slvCycKind, TGC_RMW);
        // hold the local request across an edge inside the locked cycle
        userReq = 1'b1;
        @(posedge sys_clk);
        #1 chk(userGnt, 1'b0);
        userReq = 1'b0;
        op(1'b1, 29'h2, 8'h81, 64'h5a, 2'h1, TGC_RMW, 1'b1, 1'b1);
        cmdLock = 1'b0;
        // local read, then a local write read back over the bus
        @(posedge sys_clk);
        #1 {userReq, userAdr} = {1'b1, 4'h2};
        @(posedge sys_clk);
        #1 {userReq, userWe, userAdr} = {2'b11, 4'h5};
        chk(userRdat, mem[2]);
        userWdat = 64'hfeedface00c0ffee;
        @(posedge sys_clk);
        #1 {userReq, userWe} = 2'b00;
        mem[5] = userWdat;
        // bus reset refuses commands but keeps the store
        ifaceReset = 1'b1;
        repeat (3) @(posedge sys_clk);
        #1 chk(cmdReady, 1'b0);
        ifaceReset = 1'b0;
        op(1'b0, 29'h5, 8'hf0, '0, 2'h0, TGC_SINGLE, 1'b1, 1'b1);
        completeRun();
    end
endmodule // bus_endpoint_signal_semantics_test
`default_nettype wire
